// *** rtl/cpd_pkg.sv ***
// Constants shared by the command-port digital I/O block
package cpd_pkg;
    // ==========================================================
    // Clock and serial framing
    localparam int CLK_HZ = 25_000_000; // Core clock rate
    localparam int BAUD_RATE = 9600; // Default link rate
    localparam int BIT_CYCLES = CLK_HZ / BAUD_RATE; // Rounded down
    localparam logic [11:0] BIT_LAST = 12'(BIT_CYCLES - 1);
    localparam logic [11:0] HALF_BIT = 12'(BIT_CYCLES / 2);
    localparam logic [3:0] RX_STOP_BIT = 4'h9; // Start, 7 data, parity, stop
    localparam logic [3:0] TX_FRAME_LAST = 4'h9; // Ten bits per frame
    // ==========================================================
    // Port counts and command limits
    localparam int PORT_COUNT = 8;
    localparam logic [3:0] ARG_DIGITS = 4'h8; // Write pattern length
    localparam logic [1:0] ADDR_DIGITS = 2'h2; // Two decimal address digits
    localparam logic [3:0] REPLY_LAST = 4'hC; // 13 reply characters
    localparam logic [7:0] OUT_RESET = 8'h00; // All outputs off
    // ==========================================================
    // Pattern digit meanings
    localparam logic [1:0] DIG_OFF = 2'h0;
    localparam logic [1:0] DIG_ON = 2'h1;
    localparam logic [1:0] DIG_HOLD = 2'h2;
    // ==========================================================
    // Character codes, seven bits
    localparam logic [6:0] CH_CR = 7'h0D;
    localparam logic [6:0] CH_LF = 7'h0A;
    localparam logic [6:0] CH_ZERO = 7'h30;
    localparam logic [6:0] CH_TWO = 7'h32;
    localparam logic [6:0] CH_NINE = 7'h39;
    localparam logic [6:0] CH_COLON = 7'h3A;
    localparam logic [6:0] CH_A = 7'h41;
    localparam logic [6:0] CH_Z = 7'h5A;
    localparam logic [6:0] CH_P = 7'h50;
    localparam logic [6:0] CH_R = 7'h52;
    localparam logic [6:0] CH_W = 7'h57;
    // ==========================================================
    // Parser and transmitter states
    typedef enum logic [1:0] {
        PS_ADDR = 2'b00,
        PS_CMD2 = 2'b01,
        PS_ARG = 2'b10
    } cpd_parse_type;
    typedef enum logic [0:0] {
        TX_IDLE = 1'b0,
        TX_SHIFT = 1'b1
    } cpd_tx_type;
endpackage

// *** rtl/cpd_top.sv ***
// Serial command port driving eight read ports and eight write ports
`timescale 1ns/10ps
// How it works
// - Sample eight inputs; undriven reads as zero (the block has no pull-down, read_port_in is sampled as driven)
// - Query reply: thirteen characters, eight of them port states, port 8 first
// - Character 1 active, 0 inactive
// - Digit 0 off, 1 on, 2 hold
// - All outputs off after reset
// - Commands on point or multidrop port; optional handshake
// - 9600 baud, 7 data, even parity, one stop
// - No echo on the multidrop bus
// - Address from two rotary switches
// - Framing or parity error lights error flag
module cpd_top import cpd_pkg::*; #(
    parameter int BIT_DIV = BIT_CYCLES // Clock cycles per serial bit, up to 4096
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Digital ports
    input wire logic [PORT_COUNT-1:0] read_port_in,
    output logic [PORT_COUNT-1:0] write_port_out,
    // Point-to-point serial port
    input wire logic p2p_rxd,
    output logic p2p_txd,
    input wire logic p2p_cts,
    output logic p2p_rts,
    input wire logic flow_enable,
    // Multidrop serial bus
    input wire logic md_rxd,
    output logic md_txd,
    output logic md_tx_oe,
    // Axis address switches and status
    input wire logic [3:0] axis_address_switch_a,
    input wire logic [3:0] axis_address_switch_b,
    output logic comms_error_display
);
    // Bit timer end points for the chosen bit length
    localparam logic [11:0] BIT_END = 12'(BIT_DIV - 1);
    localparam logic [11:0] BIT_MID = 12'(BIT_DIV / 2);

    // ==========================================================
    // Receivers: index 0 point-to-point, index 1 multidrop
    logic rx_line [2]; // Line per receiver
    logic rx_busy [2]; // Frame in progress
    logic [11:0] rx_cnt [2]; // Bit timer
    logic [3:0] rx_bit [2]; // Bit position
    logic [7:0] rx_shift [2]; // Data plus parity
    logic rx_done [2]; // Good character pulse
    logic rx_err [2]; // Bad character pulse

    assign rx_line[0] = p2p_rxd;
    assign rx_line[1] = md_rxd;

    // Both receivers share one structure
    for (genvar g = 0; g < 2; g++) begin : g_rx
        always_ff @(posedge core_clk) begin
            rx_done[g] <= 1'b0;
            rx_err[g] <= 1'b0;
            if (rst) begin
                rx_busy[g] <= 1'b0;
                rx_cnt[g] <= 12'h000;
                rx_bit[g] <= 4'h0;
                rx_shift[g] <= 8'h00;
            end else if (!rx_busy[g]) begin
                // Falling edge starts a frame, sampled mid-bit
                if (!rx_line[g]) begin
                    rx_busy[g] <= 1'b1;
                    rx_cnt[g] <= BIT_MID;
                    rx_bit[g] <= 4'h0;
                end
            end else if (rx_cnt[g] != 12'h000) begin
                rx_cnt[g] <= rx_cnt[g] - 12'h001;
            end else begin
                rx_cnt[g] <= BIT_END;
                if (rx_bit[g] == 4'h0) begin
                    // Glitch shorter than half a bit is dropped
                    if (rx_line[g]) begin
                        rx_busy[g] <= 1'b0;
                    end else begin
                        rx_bit[g] <= 4'h1;
                    end
                end else if (rx_bit[g] != RX_STOP_BIT) begin
                    rx_shift[g] <= {rx_line[g], rx_shift[g][7:1]};
                    rx_bit[g] <= rx_bit[g] + 4'h1;
                end else begin
                    // Even parity over data and parity bit, stop must be high
                    rx_busy[g] <= 1'b0;
                    if (rx_line[g] && !(^rx_shift[g])) begin
                        rx_done[g] <= 1'b1;
                    end else begin
                        rx_err[g] <= 1'b1;
                    end
                end
            end
        end
    end

    // Point-to-point wins when both finish in one cycle; the other is lost
    logic byte_valid; // Character accepted this cycle
    logic [6:0] byte_char; // Character value
    logic byte_src; // Port the character came from
    assign byte_valid = rx_done[0] | rx_done[1];
    assign byte_char = rx_done[0] ? rx_shift[0][6:0] : rx_shift[1][6:0];
    assign byte_src = !rx_done[0];

    // ==========================================================
    // Error display, sticky until reset
    always_ff @(posedge core_clk) begin
        if (rst) begin
            comms_error_display <= 1'b0;
        end else if (rx_err[0] || rx_err[1]) begin
            comms_error_display <= 1'b1;
        end
    end

    // ==========================================================
    // Command parser
    cpd_parse_type pstate; // Parser state
    logic [6:0] addr_val; // Received address
    logic [1:0] addr_cnt; // Address digits seen
    logic [6:0] cmd_first; // First command letter
    logic [6:0] cmd_second; // Second command letter
    logic [15:0] arg_bits; // Two bits per digit, last digit low
    logic [3:0] arg_cnt; // Digits seen
    logic arg_ok; // Every digit was 0, 1 or 2
    logic own_addr; // Command is for this axis
    logic do_query; // Query command complete
    logic do_write; // Write command complete

    // Decimal address from the two rotary switches
    function automatic logic [6:0] addr_of(input logic [3:0] tens, input logic [3:0] units);
        addr_of = 7'({tens, 3'b000}) + 7'({tens, 1'b0}) + 7'(units);
    endfunction

    assign own_addr = (addr_val == addr_of(axis_address_switch_a,
                                           axis_address_switch_b));
    assign do_query = byte_valid && (byte_char == CH_CR) && own_addr && (pstate == PS_ARG)
        && (cmd_first == CH_R) && (cmd_second == CH_P) && (arg_cnt == 4'h0);
    assign do_write = byte_valid && (byte_char == CH_CR) && own_addr && (pstate == PS_ARG)
        && (cmd_first == CH_W) && (cmd_second == CH_P) && arg_ok
        && (arg_cnt == ARG_DIGITS);

    // Parse address, two letters, then argument digits up to carriage return
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pstate <= PS_ADDR;
            addr_val <= 7'h00;
            addr_cnt <= 2'h0;
            cmd_first <= 7'h00;
            cmd_second <= 7'h00;
            arg_bits <= 16'h0000;
            arg_cnt <= 4'h0;
            arg_ok <= 1'b1;
        end else if (byte_valid) begin
            if (byte_char == CH_CR) begin
                // End of line, start afresh
                pstate <= PS_ADDR;
                addr_val <= 7'h00;
                addr_cnt <= 2'h0;
                arg_cnt <= 4'h0;
                arg_ok <= 1'b1;
            end else begin
                case (pstate)
                    PS_ADDR: begin
                        if (byte_char >= CH_ZERO && byte_char <= CH_NINE
                            && addr_cnt != ADDR_DIGITS) begin
                            addr_val <= addr_of(addr_val[3:0], 4'(byte_char - CH_ZERO));
                            addr_cnt <= addr_cnt + 2'h1;
                        end else if (byte_char >= CH_A && byte_char <= CH_Z) begin
                            cmd_first <= byte_char;
                            pstate <= PS_CMD2;
                        end
                    end
                    PS_CMD2: begin
                        cmd_second <= byte_char;
                        pstate <= PS_ARG;
                    end
                    PS_ARG: begin
                        // Extra or foreign digits spoil the pattern
                        if (byte_char >= CH_ZERO && byte_char <= CH_TWO
                            && arg_cnt != ARG_DIGITS) begin
                            arg_bits <= {arg_bits[13:0], 2'(byte_char - CH_ZERO)};
                            arg_cnt <= arg_cnt + 4'h1;
                        end else begin
                            arg_ok <= 1'b0;
                        end
                    end
                    default: begin
                        pstate <= PS_ADDR;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Write ports: every digit lands in the same clock edge
    for (genvar i = 0; i < PORT_COUNT; i++) begin : g_out
        always_ff @(posedge core_clk) begin
            if (rst) begin
                write_port_out[i] <= OUT_RESET[i];
            end else if (do_write) begin
                if (arg_bits[2*i +: 2] == DIG_ON) begin
                    write_port_out[i] <= 1'b1;
                end else if (arg_bits[2*i +: 2] == DIG_OFF) begin
                    write_port_out[i] <= 1'b0;
                end
                // DIG_HOLD keeps the present state
            end
        end
    end

    // ==========================================================
    // Query reply: address, colon, port 8 down to 1, CR LF
    logic reply_active; // Reply being sent
    logic [3:0] reply_idx; // Next reply character
    logic reply_port; // Port that asked
    logic [PORT_COUNT-1:0] in_snap; // Inputs caught at the query
    logic [6:0] addr_tens; // Address tens digit
    logic [6:0] addr_units; // Address units digit
    logic tx_take_reply; // Transmitter takes a reply character

    assign addr_tens = CH_ZERO + 7'(axis_address_switch_a);
    assign addr_units = CH_ZERO + 7'(axis_address_switch_b);

    // Character at each reply position
    function automatic logic [6:0] reply_char(input logic [3:0] idx,
                                              input logic [PORT_COUNT-1:0] snap,
                                              input logic [6:0] tens,
                                              input logic [6:0] units);
        if (idx == 4'h0) begin
            reply_char = tens;
        end else if (idx == 4'h1) begin
            reply_char = units;
        end else if (idx == 4'h2) begin
            reply_char = CH_COLON;
        end else if (idx < REPLY_LAST - 4'h1) begin
            // Position 3 is port 8, position 10 is port 1
            reply_char = CH_ZERO + 7'(snap[3'(4'hA - idx)]);
        end else if (idx == REPLY_LAST - 4'h1) begin
            reply_char = CH_CR;
        end else begin
            reply_char = CH_LF;
        end
    endfunction

    // A query during a reply is ignored rather than queued
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reply_active <= 1'b0;
            reply_idx <= 4'h0;
            reply_port <= 1'b0;
            in_snap <= 8'h00;
        end else if (do_query && !reply_active) begin
            reply_active <= 1'b1;
            reply_idx <= 4'h0;
            reply_port <= byte_src;
            in_snap <= read_port_in;
        end else if (tx_take_reply) begin
            reply_idx <= reply_idx + 4'h1;
            if (reply_idx == REPLY_LAST) begin
                reply_active <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Echo of point-to-point characters; multidrop is never echoed
    logic echo_pend; // Echo character waiting
    logic [6:0] echo_char; // Character to echo
    logic tx_take_echo; // Transmitter takes the echo

    always_ff @(posedge core_clk) begin
        if (rst) begin
            echo_pend <= 1'b0;
            echo_char <= 7'h00;
        end else if (rx_done[0]) begin
            echo_pend <= 1'b1; // Set wins over take
            echo_char <= rx_shift[0][6:0];
        end else if (tx_take_echo) begin
            echo_pend <= 1'b0;
        end
        // rx_done[1] deliberately never reaches here
    end

    // ==========================================================
    // Shared transmitter
    cpd_tx_type tx_state; // Transmitter state
    logic [9:0] tx_shift; // Frame, LSB first
    logic [11:0] tx_cnt; // Bit timer
    logic [3:0] tx_bit; // Bit index
    logic tx_port; // Destination port
    logic p2p_clear; // Host allows sending
    logic [6:0] tx_char; // Character chosen

    assign p2p_clear = !flow_enable || p2p_cts;
    assign tx_take_echo = (tx_state == TX_IDLE) && echo_pend && p2p_clear;
    assign tx_take_reply = (tx_state == TX_IDLE) && !tx_take_echo && reply_active
        && (reply_port || p2p_clear);
    assign tx_char = tx_take_echo ? echo_char
        : reply_char(reply_idx, in_snap, addr_tens, addr_units);

    // Frame: start, 7 data, even parity, stop
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tx_state <= TX_IDLE;
            tx_shift <= 10'h3FF;
            tx_cnt <= 12'h000;
            tx_bit <= 4'h0;
            tx_port <= 1'b0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    if (tx_take_echo || tx_take_reply) begin
                        tx_shift <= {1'b1, ^tx_char, tx_char, 1'b0};
                        tx_port <= tx_take_reply && reply_port;
                        tx_cnt <= BIT_END;
                        tx_bit <= 4'h0;
                        tx_state <= TX_SHIFT;
                    end
                end
                TX_SHIFT: begin
                    if (tx_cnt != 12'h000) begin
                        tx_cnt <= tx_cnt - 12'h001;
                    end else if (tx_bit == TX_FRAME_LAST) begin
                        tx_state <= TX_IDLE;
                        tx_shift <= 10'h3FF;
                    end else begin
                        tx_cnt <= BIT_END;
                        tx_bit <= tx_bit + 4'h1;
                        tx_shift <= {1'b1, tx_shift[9:1]};
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    // Line drivers, registered one cycle behind the shifter
    always_ff @(posedge core_clk) begin
        if (rst) begin
            p2p_txd <= 1'b1;
            md_txd <= 1'b1;
            md_tx_oe <= 1'b0;
        end else begin
            p2p_txd <= (tx_state == TX_SHIFT && !tx_port) ? tx_shift[0] : 1'b1;
            md_txd <= (tx_state == TX_SHIFT && tx_port) ? tx_shift[0] : 1'b1;
            md_tx_oe <= (tx_state == TX_SHIFT) && tx_port; // Release bus when idle
        end
    end

    // Ready to receive except while reply characters wait for the transmitter
    always_ff @(posedge core_clk) begin
        if (rst) begin
            p2p_rts <= 1'b0;
        end else begin
            p2p_rts <= !reply_active;
        end
    end
endmodule

// *** dv/cpd_monitor.sv ***
// Port-level checker for the command-port digital I/O block
`timescale 1ns/10ps
module cpd_monitor import cpd_pkg::*; #(
    parameter int BIT_DIV = BIT_CYCLES // Clock cycles per serial bit
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Observed outputs
    input wire logic [PORT_COUNT-1:0] write_port_out,
    input wire logic p2p_txd,
    input wire logic p2p_rts,
    input wire logic md_txd,
    input wire logic md_tx_oe,
    input wire logic comms_error_display
);
    // ==========================================================
    // Helper logic
    // Low run on the serial line; any low run spans whole bits
    int low_run;
    always_ff @(posedge core_clk) begin
        if (rst || p2p_txd) begin
            low_run <= 0;
        end else begin
            low_run <= low_run + 1;
        end
    end
    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    a_reset_outputs_off: assert property ($fell(rst) |-> write_port_out == OUT_RESET)
        else $error("write ports not off after reset");
    a_reset_lines_idle: assert property ($fell(rst) |-> p2p_txd && md_txd && !md_tx_oe)
        else $error("serial lines not idle after reset");
    a_rts_after_reset: assert property ($fell(rst) |=> p2p_rts)
        else $error("ready not raised after reset");
    a_error_reset_clear: assert property ($fell(rst) |-> !comms_error_display)
        else $error("error flag set after reset");
    a_error_stays_set: assert property (comms_error_display |=> comms_error_display)
        else $error("error flag cleared without reset");
    a_outputs_move_together: assert property (
        $changed(write_port_out) |=> $stable(write_port_out) [*8])
        else $error("write ports changed in steps");
    a_bit_time_held: assert property ($rose(p2p_txd) |-> low_run >= BIT_DIV)
        else $error("serial bit shorter than one bit time");
    a_md_start_enabled: assert property ($fell(md_txd) |-> ##[1:2] md_tx_oe)
        else $error("multidrop start bit sent undriven");
    a_md_enable_on_start: assert property ($rose(md_tx_oe) |-> !md_txd)
        else $error("multidrop enable without start bit");
endmodule
bind cpd_top cpd_monitor #(.BIT_DIV(BIT_DIV)) u_cpd_monitor (.core_clk(core_clk), .rst(rst),
    .write_port_out(write_port_out), .p2p_txd(p2p_txd), .p2p_rts(p2p_rts),
    .md_txd(md_txd), .md_tx_oe(md_tx_oe), .comms_error_display(comms_error_display));

// *** dv/cpd_host_model.sv ***
// Host computer model talking 7E1 text to the block
`timescale 1ns/10ps
module cpd_host_model import cpd_pkg::*; #(
    parameter int BIT_N = BIT_CYCLES // Device bit length in clock cycles
) (
    // Clock
    input wire logic core_clk,
    // Host drive
    output logic p2p_rxd,
    output logic md_rxd,
    output logic p2p_cts,
    // Device drive
    input wire logic p2p_txd,
    input wire logic p2p_rts,
    input wire logic md_tx_oe
);
    logic [6:0] rx_q[$]; // Characters heard from the device
    int rx_bad = 0; // Frames with bad parity or stop
    int md_drive = 0; // Cycles the device drove multidrop
    int host_err = 0; // Ready waits that ran out
    // Lines idle high, host always ready to take replies
    initial begin
        p2p_rxd = 1'b1;
        md_rxd = 1'b1;
        p2p_cts = 1'b1;
    end
    // One frame, start, 7 bits LSB first, even parity, stop
    task automatic send_char(input bit md, input logic [6:0] ch, input bit bad_par);
        logic [9:0] fr;
        int n;
        fr = {1'b1, (^ch) ^ bad_par, ch, 1'b0};
        n = 0;
        // Honour the device's ready on the point port
        while (!md && p2p_rts !== 1'b1 && n < 20000) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 20000) host_err++;
        for (int i = 0; i < 10; i++) begin
            if (md) md_rxd = fr[i];
            else p2p_rxd = fr[i];
            repeat (BIT_N) @(negedge core_clk);
        end
        // Gap so a whole echo frame drains before the next character
        repeat (11 * BIT_N) @(negedge core_clk);
    endtask
    // Whole command line ended by carriage return
    task automatic send_line(input bit md, input string s);
        for (int i = 0; i < s.len(); i++) send_char(md, 7'(s[i]), 1'b0);
        send_char(md, CH_CR, 1'b0);
    endtask
    // Receiver, samples mid-bit
    always begin : rx_proc
        logic [8:0] b;
        @(negedge core_clk);
        if (p2p_txd === 1'b0) begin
            repeat (BIT_N / 2) @(negedge core_clk);
            for (int i = 0; i < 9; i++) begin
                repeat (BIT_N) @(negedge core_clk);
                b[i] = p2p_txd;
            end
            if (b[8] !== 1'b1 || ^b[7:0] !== 1'b0) rx_bad++;
            rx_q.push_back(b[6:0]);
        end
    end
    // Count multidrop drive cycles
    always @(posedge core_clk) begin
        if (md_tx_oe === 1'b1) md_drive++;
    end
endmodule

// *** dv/cpd_top_test.sv ***
// Self-checking bench for the command-port digital I/O block
`timescale 1ns/10ps
module cpd_top_test import cpd_pkg::*;;
    // ==========================================================
    // Stimulus and observed signals
    logic core_clk = 1'b0;
    logic rst = 1'b1; // Held for five cycles
    logic flow_enable = 1'b1; // Ready handshake in use
    logic [7:0] read_port_in = 8'h00;
    logic [3:0] axis_address_switch_a = 4'h0; // Address 03
    logic [3:0] axis_address_switch_b = 4'h3;
    logic [7:0] write_port_out;
    logic p2p_rxd, p2p_txd, p2p_cts, p2p_rts, md_rxd, md_txd, md_tx_oe, comms_error_display;
    logic [7:0] outs_exp; // Expected write ports
    int n_mismatch = 0;
    int checked = 0;
    localparam int BIT_DIV = 16; // Short bit time keeps the run brief
    always #20 core_clk = ~core_clk;
    cpd_top #(.BIT_DIV(BIT_DIV)) u_cpd_top (.core_clk(core_clk), .rst(rst),
        .read_port_in(read_port_in),
        .write_port_out(write_port_out), .p2p_rxd(p2p_rxd), .p2p_txd(p2p_txd),
        .p2p_cts(p2p_cts), .p2p_rts(p2p_rts), .flow_enable(flow_enable), .md_rxd(md_rxd),
        .md_txd(md_txd), .md_tx_oe(md_tx_oe), .axis_address_switch_a(axis_address_switch_a),
        .axis_address_switch_b(axis_address_switch_b),
        .comms_error_display(comms_error_display));
    cpd_host_model #(.BIT_N(BIT_DIV)) u_cpd_host_model (.core_clk(core_clk),
        .p2p_rxd(p2p_rxd), .md_rxd(md_rxd), .p2p_cts(p2p_cts), .p2p_txd(p2p_txd),
        .p2p_rts(p2p_rts), .md_tx_oe(md_tx_oe));
    // ==========================================================
    // Shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Expected ports after a pattern: first digit is port 8
    function automatic logic [7:0] apply_pat(input logic [7:0] old, input string s);
        logic [7:0] r;
        r = old;
        for (int i = 0; i < 8; i++) begin
            if (s[i] == "0") r[7 - i] = 1'b0;
            else if (s[i] == "1") r[7 - i] = 1'b1;
        end
        return r;
    endfunction
    // Write command then compare all ports
    task automatic do_write(input bit md, input string pat);
        u_cpd_host_model.send_line(md, {"3WP", pat});
        repeat (4) @(negedge core_clk);
        outs_exp = apply_pat(outs_exp, pat);
        check(write_port_out, outs_exp, "write ports");
    endtask
    // ==========================================================
    // Scenarios
    task automatic test_reset();
        check(write_port_out, OUT_RESET, "ports at reset");
        check({4'h0, p2p_txd, md_txd, md_tx_oe, p2p_rts}, 8'h0D, "lines at reset");
        check(8'(comms_error_display), 8'h00, "error at reset");
        $display("test_reset done");
    endtask
    // Point port write: on, off and hold from all-off
    task automatic test_write_p2p();
        do_write(1'b0, "10201010");
        $display("test_write_p2p done");
    endtask
    // Multidrop write holds set ports; bus never driven
    task automatic test_write_md();
        u_cpd_host_model.md_drive = 0;
        u_cpd_host_model.rx_q.delete();
        do_write(1'b1, "20120121");
        check(8'(u_cpd_host_model.md_drive), 8'h00, "multidrop echo");
        check(8'(u_cpd_host_model.rx_q.size()), 8'h00, "stray reply");
        $display("test_write_md done");
    endtask
    // Query: address, colon, port 8 first, CR LF
    task automatic test_query();
        int n;
        int base;
        logic [6:0] e;
        read_port_in = 8'h8C; // Ends differ so order shows
        u_cpd_host_model.rx_q.delete();
        u_cpd_host_model.send_line(1'b0, "3RP");
        n = 0;
        while (n < 20000 && !(u_cpd_host_model.rx_q.size() >= 13
               && u_cpd_host_model.rx_q[$] == CH_LF)) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 20000) begin
            n_mismatch++;
            $display("[ERR] %0t reply never finished", $time);
            finish_test();
        end
        base = u_cpd_host_model.rx_q.size() - 13;
        for (int k = 0; k < 13; k++) begin
            if (k < 2) e = CH_ZERO + 7'(k == 0 ? axis_address_switch_a : axis_address_switch_b);
            else if (k == 2) e = CH_COLON;
            else if (k < 11) e = CH_ZERO + 7'(read_port_in[10 - k]);
            else e = (k == 11) ? CH_CR : CH_LF;
            check(8'(u_cpd_host_model.rx_q[base + k]), 8'(e), "reply char");
        end
        check(8'(u_cpd_host_model.rx_bad), 8'h00, "reply framing");
        $display("test_query done");
    endtask
    // Multidrop query: 13 driven frames of 10 bits, ready low meanwhile
    task automatic test_query_md();
        int n;
        u_cpd_host_model.md_drive = 0;
        u_cpd_host_model.rx_q.delete();
        u_cpd_host_model.send_line(1'b1, "3RP");
        check(8'(p2p_rts), 8'h00, "ready during reply");
        n = 0;
        while (n < 20000 && p2p_rts !== 1'b1) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 20000) begin
            n_mismatch++;
            $display("[ERR] %0t multidrop reply never finished", $time);
            finish_test();
        end
        // Last frame is still going out when ready returns
        repeat (11 * BIT_DIV) @(negedge core_clk);
        check(8'(u_cpd_host_model.md_drive - 130 * BIT_DIV), 8'h00, "md drive");
        check(8'(u_cpd_host_model.rx_q.size()), 8'h00, "reply on point port");
        $display("test_query_md done");
    endtask
    // Bad parity lights the error flag
    task automatic test_comms_error();
        check(8'(comms_error_display), 8'h00, "error before");
        u_cpd_host_model.send_char(1'b0, CH_A, 1'b1);
        check(8'(comms_error_display), 8'h01, "error after");
        check(write_port_out, outs_exp, "ports kept");
        check(8'(u_cpd_host_model.host_err), 8'h00, "ready waits");
        $display("test_comms_error done");
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        outs_exp = OUT_RESET;
        repeat (5) @(negedge core_clk);
        rst = 1'b0;
        repeat (2) @(negedge core_clk);
        test_reset();
        test_write_p2p();
        test_write_md();
        test_query();
        test_query_md();
        test_comms_error();
        finish_test();
    end
endmodule
